// ---- common/alr_pkg.sv ----
package alr_pkg;

  // Register offsets, pointer values as seen on the serial bus.
  localparam logic [7:0] REG_IRQ_FLAG   = 8'h00;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h01;
  localparam logic [7:0] REG_CONFIG     = 8'h02;
  localparam logic [7:0] REG_RES_HIGH   = 8'h03;
  localparam logic [7:0] REG_RES_LOW    = 8'h04;
  localparam logic [7:0] REG_UPPER      = 8'h05;
  localparam logic [7:0] REG_LOWER      = 8'h06;
  localparam logic [7:0] REG_PTIMER     = 8'h07;

  // Values after reset.
  localparam logic [7:0] IRQ_FLAG_RST   = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST     = 8'h03;
  localparam logic [7:0] UPPER_RST      = 8'hFF;
  localparam logic [7:0] LOWER_RST      = 8'h00;
  localparam logic [7:0] PTIMER_RST     = 8'hFF;

  // Configuration field positions.
  localparam int CFG_BACK_TO_BACK_CONV_BIT   = 7;
  localparam int CFG_MANUAL_BIT = 6;
  localparam int CFG_CDR_BIT    = 3;
  localparam int CFG_TIM_LSB    = 0;

  // Integration time codes.
  localparam logic [2:0] TIM_800MS = 3'h0;
  localparam logic [2:0] TIM_100MS = 3'h3;

  // Autoranging limits on the exponent and the result.
  localparam logic [3:0]  AUTO_HIGH_EXP = 4'hC;
  localparam logic [11:0] AUTO_LOW_VAL  = 12'h010;
  localparam logic [3:0]  LUX_OVERRANGE = 4'hF;

  // Timing.
  localparam int unsigned SYS_CLK_HZ      = 32'h017D_7840;
  localparam int unsigned MS_PER_S        = 32'h0000_03E8;
  localparam int unsigned MEAS_PERIOD_MS  = 32'h0000_0320;
  localparam int unsigned PERSIST_TICK_MS = 32'h0000_0064;
  localparam int unsigned MEAS_PERIOD_CYC = SYS_CLK_HZ / MS_PER_S * MEAS_PERIOD_MS;
  localparam int unsigned PERSIST_TICK_CYC = SYS_CLK_HZ / MS_PER_S * PERSIST_TICK_MS;

  // Seven-bit bus address; chosen default, a parameter of the top.
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h4A;

  typedef enum logic [6:0] {
    LS_IDLE  = 7'b000_0001,
    LS_ADDR  = 7'b000_0010,
    LS_AACK  = 7'b000_0100,
    LS_WBYTE = 7'b000_1000,
    LS_WACK  = 7'b001_0000,
    LS_RBYTE = 7'b010_0000,
    LS_RACK  = 7'b100_0000
  } alr_link_state_t;

endpackage

// ---- logic/alr_core.sv ----
// Behaviour
// - Persistent out-of-window light sets flag when enabled
// - Reading status register clears the flag
// - Writing zero enable clears the flag
// - Interrupt pin pulled low while flag set
// - Enable zero: no flag, no pin
// - Non-continuous: one start every 800 ms
// - Continuous: next start right after finish
// - Scheduling identical in auto and manual
// - Auto mode: fields show autorange, writes ignored
// - Manual mode: host fields drive conversions
// - Divider bit selects full or eighth current
// - Time codes map 800 down to 6.25 ms
// - Integration time defaults to 100 ms
// - Result bytes hold exponent and mantissa split
// - Exponent 1111 reports over range
// - No result update during a bus read
// - Result updates resume at STOP
// - Timer times 100 ms; zero is immediate; code waits (timer + 1) x 100 ms when nonzero
// - Limits compared in result high byte layout
// - Upper low bits ones, lower zeros
`timescale 1ns/1ps
`default_nettype none
module alr_core #(
  parameter int unsigned MEAS_PERIOD_CYC  = alr_pkg::MEAS_PERIOD_CYC,
  parameter int unsigned PERSIST_TICK_CYC = alr_pkg::PERSIST_TICK_CYC,
  parameter logic [6:0]  DEV_ADDR         = alr_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        clk_link_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic             irq_n_out,
  output logic             irq_n_oe_out,
  input  wire logic        conv_done_in,
  input  wire logic [11:0] conv_value_in,
  output logic             conv_start_out,
  output logic [2:0]       conv_time_sel_out,
  output logic             conv_divider_out
);

  // ---------------- Link domain ----------------
  logic       lrst_meta_q, lrst_q;
  logic [1:0] scl_sync_q, sda_sync_q;
  logic       scl_prev_q, sda_prev_q;
  logic       ak_s1_q, ak_s2_q, ak_s3_q;
  alr_pkg::alr_link_state_t lstate_q;
  logic [7:0] shift_q, tx_q, ptr_q, rd_hold_q, req_addr_q, req_data_q;
  logic [3:0] bitcnt_q;
  logic       rw_q, got_ptr_q, nack_q, req_wr_q, req_tgl_q, freeze_q;
  logic       sda_oe_q;
  logic       scl_hi, scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge clk_link_in) begin
    lrst_meta_q <= reset_in;
    lrst_q      <= lrst_meta_q;
  end

  always_ff @(posedge clk_link_in) begin
    scl_sync_q <= {scl_sync_q[0], scl_in};
    sda_sync_q <= {sda_sync_q[0], sda_in};
    scl_prev_q <= scl_sync_q[1];
    sda_prev_q <= sda_sync_q[1];
  end

  assign scl_hi    = scl_sync_q[1] & scl_prev_q;
  assign scl_rise  = scl_sync_q[1] & ~scl_prev_q;
  assign scl_fall  = ~scl_sync_q[1] & scl_prev_q;
  assign bus_start = scl_hi & sda_prev_q & ~sda_sync_q[1];
  assign bus_stop  = scl_hi & ~sda_prev_q & sda_sync_q[1];

  logic [7:0] rd_data_q;
  logic       ack_tgl_q;

  always_ff @(posedge clk_link_in) begin
    ak_s1_q <= ack_tgl_q;
    ak_s2_q <= ak_s1_q;
    ak_s3_q <= ak_s2_q;
    if (ak_s2_q ^ ak_s3_q) begin
      rd_hold_q <= rd_data_q;
    end
  end

  always_ff @(posedge clk_link_in) begin
    if (lrst_q) begin
      lstate_q   <= alr_pkg::LS_IDLE;
      shift_q    <= 8'h00;
      tx_q       <= 8'h00;
      ptr_q      <= 8'h00;
      bitcnt_q   <= 4'h0;
      rw_q       <= 1'b0;
      got_ptr_q  <= 1'b0;
      nack_q     <= 1'b0;
      req_wr_q   <= 1'b0;
      req_tgl_q  <= 1'b0;
      req_addr_q <= 8'h00;
      req_data_q <= 8'h00;
      freeze_q   <= 1'b0;
      sda_oe_q   <= 1'b0;
    end else if (bus_stop) begin
      lstate_q <= alr_pkg::LS_IDLE;
      freeze_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (bus_start) begin
      lstate_q <= alr_pkg::LS_ADDR;
      bitcnt_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else begin
      unique case (lstate_q)
        alr_pkg::LS_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        alr_pkg::LS_ADDR: begin
          if (scl_rise) begin
            shift_q  <= {shift_q[6:0], sda_sync_q[1]};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == 4'h8) begin
            if (shift_q[7:1] == DEV_ADDR) begin
              freeze_q  <= 1'b1;
              sda_oe_q  <= 1'b1;
              rw_q      <= shift_q[0];
              got_ptr_q <= 1'b0;
              lstate_q  <= alr_pkg::LS_AACK;
              if (shift_q[0]) begin
                req_wr_q   <= 1'b0;
                req_addr_q <= ptr_q;
                req_tgl_q  <= ~req_tgl_q;
              end
            end else begin
              lstate_q <= alr_pkg::LS_IDLE;
            end
          end
        end
        alr_pkg::LS_AACK: begin
          if (scl_fall) begin
            bitcnt_q <= 4'h0;
            if (rw_q) begin
              sda_oe_q <= ~rd_hold_q[7];
              tx_q     <= {rd_hold_q[6:0], 1'b0};
              lstate_q <= alr_pkg::LS_RBYTE;
            end else begin
              sda_oe_q <= 1'b0;
              lstate_q <= alr_pkg::LS_WBYTE;
            end
          end
        end
        alr_pkg::LS_WBYTE: begin
          if (scl_rise) begin
            shift_q  <= {shift_q[6:0], sda_sync_q[1]};
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (scl_fall && bitcnt_q == 4'h8) begin
            sda_oe_q <= 1'b1;
            lstate_q <= alr_pkg::LS_WACK;
            if (!got_ptr_q) begin
              ptr_q     <= shift_q;
              got_ptr_q <= 1'b1;
            end else begin
              req_wr_q   <= 1'b1;
              req_addr_q <= ptr_q;
              req_data_q <= shift_q;
              req_tgl_q  <= ~req_tgl_q;
              ptr_q      <= ptr_q + 8'h01;
            end
          end
        end
        alr_pkg::LS_WACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            bitcnt_q <= 4'h0;
            lstate_q <= alr_pkg::LS_WBYTE;
          end
        end
        alr_pkg::LS_RBYTE: begin
          if (scl_rise) begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bitcnt_q == 4'h8) begin
              sda_oe_q   <= 1'b0;
              lstate_q   <= alr_pkg::LS_RACK;
              ptr_q      <= ptr_q + 8'h01;
              req_wr_q   <= 1'b0;
              req_addr_q <= ptr_q + 8'h01;
              req_tgl_q  <= ~req_tgl_q;
            end else begin
              sda_oe_q <= ~tx_q[7];
              tx_q     <= {tx_q[6:0], 1'b0};
            end
          end
        end
        alr_pkg::LS_RACK: begin
          if (scl_rise) begin
            nack_q <= sda_sync_q[1];
          end else if (scl_fall) begin
            bitcnt_q <= 4'h0;
            if (nack_q) begin
              lstate_q <= alr_pkg::LS_IDLE;
            end else begin
              sda_oe_q <= ~rd_hold_q[7];
              tx_q     <= {rd_hold_q[6:0], 1'b0};
              lstate_q <= alr_pkg::LS_RBYTE;
            end
          end
        end
      endcase
    end
  end

  // Open drain: the data line is only ever pulled low.
  assign sda_out    = 1'b0;
  assign sda_oe_out = sda_oe_q;

  // ---------------- System domain ----------------
  logic rq_s1_q, rq_s2_q, rq_s3_q, fz_s1_q, fz_s2_q;

  always_ff @(posedge clk_sys_in) begin
    rq_s1_q <= req_tgl_q;
    rq_s2_q <= rq_s1_q;
    rq_s3_q <= rq_s2_q;
    fz_s1_q <= freeze_q;
    fz_s2_q <= fz_s1_q;
  end

  logic acc, acc_wr, acc_rd, rd_flag, wr_en_zero;
  assign acc        = rq_s2_q ^ rq_s3_q;
  assign acc_wr     = acc & req_wr_q;
  assign acc_rd     = acc & ~req_wr_q;
  assign rd_flag    = acc_rd && req_addr_q == alr_pkg::REG_IRQ_FLAG;
  assign wr_en_zero = acc_wr && req_addr_q == alr_pkg::REG_IRQ_ENABLE && !req_data_q[0];

  logic        irq_flag_q, irq_en_q, back_to_back_conv_q, manual_q, cdr_man_q, cdr_auto_q;
  logic [2:0]  tim_man_q, tim_auto_q;
  logic [7:0]  upper_q, lower_q, ptimer_q;
  logic [11:0] res_q, pend_val_q;
  logic        pend_q, irq_oe_q, irq_low_q;
  logic        cdr_eff;
  logic [2:0]  tim_eff;
  logic [7:0]  cfg_rd;

  assign cdr_eff = manual_q ? cdr_man_q : cdr_auto_q;
  assign tim_eff = manual_q ? tim_man_q : tim_auto_q;
  assign cfg_rd  = {back_to_back_conv_q, manual_q, 2'b00, cdr_eff, tim_eff};

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      irq_en_q  <= alr_pkg::IRQ_ENABLE_RST[0];
      back_to_back_conv_q    <= alr_pkg::CONFIG_RST[alr_pkg::CFG_BACK_TO_BACK_CONV_BIT];
      manual_q  <= alr_pkg::CONFIG_RST[alr_pkg::CFG_MANUAL_BIT];
      cdr_man_q <= alr_pkg::CONFIG_RST[alr_pkg::CFG_CDR_BIT];
      tim_man_q <= alr_pkg::CONFIG_RST[alr_pkg::CFG_TIM_LSB +: 3];
      upper_q   <= alr_pkg::UPPER_RST;
      lower_q   <= alr_pkg::LOWER_RST;
      ptimer_q  <= alr_pkg::PTIMER_RST;
    end else if (acc_wr) begin
      unique case (req_addr_q)
        alr_pkg::REG_IRQ_ENABLE: irq_en_q <= req_data_q[0];
        alr_pkg::REG_CONFIG: begin
          back_to_back_conv_q   <= req_data_q[alr_pkg::CFG_BACK_TO_BACK_CONV_BIT];
          manual_q <= req_data_q[alr_pkg::CFG_MANUAL_BIT];
          if (req_data_q[alr_pkg::CFG_MANUAL_BIT]) begin
            cdr_man_q <= req_data_q[alr_pkg::CFG_CDR_BIT];
            tim_man_q <= req_data_q[alr_pkg::CFG_TIM_LSB +: 3];
          end
        end
        alr_pkg::REG_UPPER:  upper_q  <= req_data_q;
        alr_pkg::REG_LOWER:  lower_q  <= req_data_q;
        alr_pkg::REG_PTIMER: ptimer_q <= req_data_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rd_data_q <= 8'h00;
      ack_tgl_q <= 1'b0;
    end else if (acc_rd) begin
      ack_tgl_q <= ~ack_tgl_q;
      unique case (req_addr_q)
        alr_pkg::REG_IRQ_FLAG:   rd_data_q <= {7'h00, irq_flag_q};
        alr_pkg::REG_IRQ_ENABLE: rd_data_q <= {7'h00, irq_en_q};
        alr_pkg::REG_CONFIG:     rd_data_q <= cfg_rd;
        alr_pkg::REG_RES_HIGH:   rd_data_q <= res_q[11:4];
        alr_pkg::REG_RES_LOW:    rd_data_q <= {4'h0, res_q[3:0]};
        alr_pkg::REG_UPPER:      rd_data_q <= upper_q;
        alr_pkg::REG_LOWER:      rd_data_q <= lower_q;
        alr_pkg::REG_PTIMER:     rd_data_q <= ptimer_q;
        default:                 rd_data_q <= 8'h00;
      endcase
    end
  end

  // Conversion scheduling; the same path serves auto and manual mode.
  logic [24:0] sched_cnt_q;
  logic        busy_q, start_q;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || sched_cnt_q == 25'(MEAS_PERIOD_CYC - 1)) begin
      sched_cnt_q <= 25'h000_0000;
    end else begin
      sched_cnt_q <= sched_cnt_q + 25'h000_0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      busy_q  <= 1'b0;
      start_q <= 1'b0;
    end else begin
      start_q <= ~busy_q & ~start_q & (back_to_back_conv_q | sched_cnt_q == 25'h000_0000);
      if (start_q) begin
        busy_q <= 1'b1;
      end else if (conv_done_in) begin
        busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      conv_time_sel_out <= alr_pkg::TIM_100MS;
      conv_divider_out  <= 1'b0;
    end else begin
      conv_time_sel_out <= tim_eff;
      conv_divider_out  <= cdr_eff;
    end
  end
  assign conv_start_out = start_q;

  // Autoranging; shorter codes than 100 ms are never chosen here.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      tim_auto_q <= alr_pkg::TIM_100MS;
      cdr_auto_q <= 1'b0;
    end else if (conv_done_in && !manual_q) begin
      if (conv_value_in[11:8] >= alr_pkg::AUTO_HIGH_EXP) begin
        if (tim_auto_q != alr_pkg::TIM_100MS) begin
          tim_auto_q <= tim_auto_q + 3'h1;
        end else begin
          cdr_auto_q <= 1'b1;
        end
      end else if (conv_value_in < alr_pkg::AUTO_LOW_VAL) begin
        if (cdr_auto_q) begin
          cdr_auto_q <= 1'b0;
        end else if (tim_auto_q != alr_pkg::TIM_800MS) begin
          tim_auto_q <= tim_auto_q - 3'h1;
        end
      end
    end
  end

  // Results held back while a bus transaction owns them.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      res_q      <= 12'h000;
      pend_q     <= 1'b0;
      pend_val_q <= 12'h000;
    end else if (fz_s2_q) begin
      if (conv_done_in) begin
        pend_q     <= 1'b1;
        pend_val_q <= conv_value_in;
      end
    end else if (conv_done_in) begin
      res_q  <= conv_value_in;
      pend_q <= 1'b0;
    end else if (pend_q) begin
      res_q  <= pend_val_q;
      pend_q <= 1'b0;
    end
  end

  // Threshold window and persistence.
  logic        outside_now, outside_q, tick, evt;
  logic [21:0] tick_cnt_q;
  logic [8:0]  pcnt_q;
  assign outside_now = conv_value_in > {upper_q, 4'hF} || conv_value_in < {lower_q, 4'h0};
  assign tick        = tick_cnt_q == 22'(PERSIST_TICK_CYC - 1);
  assign evt         = outside_q && (ptimer_q == 8'h00 || pcnt_q > {1'b0, ptimer_q});

  always_ff @(posedge clk_sys_in) begin
    if (reset_in || tick || !outside_q) begin
      tick_cnt_q <= 22'h00_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 22'h00_0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      outside_q <= 1'b0;
      pcnt_q    <= 9'h000;
    end else if (conv_done_in && !outside_now) begin
      outside_q <= 1'b0;
      pcnt_q    <= 9'h000;
    end else begin
      if (conv_done_in) begin
        outside_q <= 1'b1;
      end
      if (tick && pcnt_q != 9'h1FF) begin
        pcnt_q <= pcnt_q + 9'h001;
      end
    end
  end

  // A disabling write also blocks the set in its own cycle, so it always clears.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      irq_flag_q <= alr_pkg::IRQ_FLAG_RST[0];
    end else if (evt && irq_en_q && !wr_en_zero) begin
      irq_flag_q <= 1'b1;
    end else if (rd_flag || wr_en_zero) begin
      irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      irq_oe_q  <= 1'b0;
      irq_low_q <= 1'b0;
    end else begin
      irq_oe_q  <= irq_flag_q;
      irq_low_q <= 1'b0;
    end
  end
  assign irq_n_out    = irq_low_q;
  assign irq_n_oe_out = irq_oe_q;

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  AST_FLAG_NEEDS_EN: assert property ($rose(irq_flag_q) |-> irq_en_q)
    else $error("flag rose while interrupts disabled");
  AST_READ_CLEARS: assert property (rd_flag && !evt |=> !irq_flag_q)
    else $error("status read did not clear flag");
  AST_DISABLE_CLEARS: assert property (wr_en_zero |=> !irq_flag_q ##1 !irq_n_oe_out)
    else $error("disable write did not clear flag and pin");
  AST_PIN_FOLLOWS: assert property (irq_n_oe_out == $past(irq_flag_q) && !irq_n_out)
    else $error("interrupt pin does not follow flag");
  AST_EVENT_SETS: assert property (evt && irq_en_q && !wr_en_zero |=> irq_flag_q ##1 irq_n_oe_out)
    else $error("persistent event did not raise flag");
  AST_FROZEN: assert property (fz_s2_q |=> $stable(res_q))
    else $error("result changed during bus read");
  AST_BACK_TO_BACK_CONV_RESTART: assert property (back_to_back_conv_q && busy_q && conv_done_in && !start_q |-> ##2 conv_start_out)
    else $error("continuous mode did not restart");
  AST_PERIOD_START: assert property ($rose(conv_start_out) && !$past(back_to_back_conv_q) |-> $past(sched_cnt_q) == 25'h000_0000)
    else $error("start off the measurement period");
  AST_AUTO_LOCK: assert property (acc_wr && req_addr_q == alr_pkg::REG_CONFIG && !req_data_q[alr_pkg::CFG_MANUAL_BIT] |=> $stable(tim_man_q) && $stable(cdr_man_q))
    else $error("auto mode write changed manual fields");
  AST_AUTO_RANGE: assert property (!manual_q |-> tim_auto_q <= alr_pkg::TIM_100MS)
    else $error("autorange picked short integration");
  AST_INSIDE_RESET: assert property (conv_done_in && !outside_now |=> pcnt_q == 9'h000 && !outside_q)
    else $error("persistence not reset inside window");

  COV_IRQ: cover property ($rose(irq_flag_q));
  COV_READ_CLEAR: cover property (irq_flag_q && rd_flag);
  COV_FROZEN_DONE: cover property (fz_s2_q && conv_done_in);
  COV_BACK_TO_BACK_CONV: cover property (back_to_back_conv_q && conv_start_out);

endmodule
`default_nettype wire

// ---- tb/alr_i2c_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module alr_i2c_host (
  input  wire logic clk_in,
  input  wire logic sda_in,
  input  wire logic slow_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Each step changes at most one line, so data never moves while SCL falls.
  task automatic step(input logic c, input logic low);
    scl_out = c;
    sda_low_out = low;
    repeat (slow_in ? 20 : 8) @(negedge clk_in);
  endtask
  // Also used between pointer write and read phase, so no STOP splits them.
  task automatic start();
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask
  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  task automatic bit_x(input logic b, output logic s);
    step(1'b0, ~b);
    step(1'b1, ~b);
    s = sda_in;
    step(1'b0, ~b);
  endtask
  // Sends eight bits then the ninth; for reads send all ones and last high to NACK.
  task automatic xb(input logic [7:0] d, input logic last, output logic [7:0] r,
                    output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(last, ack);
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end
module tb_top;
  localparam int unsigned PERIOD = 200;
  localparam int unsigned TICK   = 50;
  localparam int          LAT    = 20;
  localparam logic [6:0]  ADDR   = alr_pkg::DEV_ADDR_DEFAULT;
  logic        clk_sys_in, clk_link_in, reset_in, scl, host_low, slow, conv_en;
  logic        sda_o, sda_oe, irq_o, irq_oe, conv_done_in, conv_start, divider;
  logic [2:0]  time_sel;
  logic [11:0] light_val;
  logic [7:0]  rst_tab [8];
  logic [15:0] d;
  int          error_cnt, compares, gap, busy, last_st;
  int          cyc = 0;
  wire logic   sda_w = ~((sda_oe & ~sda_o) | host_low);
  wire logic   irq_w = ~(irq_oe & ~irq_o);

  alr_core #(
    .MEAS_PERIOD_CYC  (PERIOD),
    .PERSIST_TICK_CYC (TICK),
    .DEV_ADDR         (ADDR)
  ) dut_u (
    .clk_sys_in        (clk_sys_in),
    .reset_in          (reset_in),
    .clk_link_in       (clk_link_in),
    .scl_in            (scl),
    .sda_in            (sda_w),
    .sda_out           (sda_o),
    .sda_oe_out        (sda_oe),
    .irq_n_out         (irq_o),
    .irq_n_oe_out      (irq_oe),
    .conv_done_in      (conv_done_in),
    .conv_value_in     (light_val),
    .conv_start_out    (conv_start),
    .conv_time_sel_out (time_sel),
    .conv_divider_out  (divider)
  );
  alr_i2c_host host_u (
    .clk_in      (clk_link_in),
    .sda_in      (sda_w),
    .slow_in     (slow),
    .scl_out     (scl),
    .sda_low_out (host_low)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    clk_link_in = 1'b0;
    #3.7;
    forever #7.5 clk_link_in = ~clk_link_in;
  end
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (conv_start === 1'b1) begin
      gap <= cyc - last_st;
      last_st <= cyc;
    end
    if (cyc > 60000) begin
      error_cnt++;
      close_out();
    end
  end
  // Converter stand-in: a start held while conv_en is low completes later.
  always @(negedge clk_sys_in) begin
    conv_done_in <= (busy == 1) && conv_en;
    if (conv_start === 1'b1) busy <= LAT;
    else if (busy > 1 || (busy == 1 && conv_en)) busy <= busy - 1;
  end

  task automatic close_out();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask
  task automatic sel(input logic [7:0] p);
    logic [7:0] r;
    logic       a;
    host_u.start();
    host_u.xb({ADDR, 1'b0}, 1'b1, r, a);
    `CHK(a, 1'b0)
    host_u.xb(p, 1'b1, r, a);
    `CHK(a, 1'b0)
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] r;
    logic       a;
    sel(p);
    host_u.xb(v, 1'b1, r, a);
    `CHK(a, 1'b0)
    host_u.stop();
    hold(8);
  endtask
  // A new light value in nv lands once the pointer is set, before any byte is fetched.
  task automatic rdn(input logic [7:0] p, input int n, input logic [11:0] nv,
                     output logic [15:0] v);
    logic [7:0] r;
    logic       a;
    sel(p);
    if (nv !== light_val) begin
      @(negedge clk_sys_in);
      light_val = nv;
      hold(80);
    end
    host_u.start();
    host_u.xb({ADDR, 1'b1}, 1'b1, r, a);
    `CHK(a, 1'b0)
    for (int i = 0; i < n; i++) begin
      host_u.xb(8'hFF, i == n - 1, r, a);
      v = {v[7:0], r};
    end
    host_u.stop();
    hold(8);
  endtask
  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    rdn(p, 1, light_val, d);
    `CHK(d[7:0], e)
  endtask

  initial begin
    reset_in = 1'b1;
    slow = 1'b0;
    conv_en = 1'b0;
    light_val = 12'h100;
    busy = 0;
    error_cnt = 0;
    compares = 0;
    rst_tab = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF};
    hold(10);
    `CHK(time_sel, 3'h3)
    reset_in = 1'b0;
    hold(4);
    for (int i = 0; i < 8; i++) rchk(i[7:0], rst_tab[i]);
    rchk(8'h08, 8'h00);
    conv_en = 1'b1;
    hold(500);
    `CHK(gap, PERIOD)
    wr(8'h03, 8'hAA);
    wr(8'h00, 8'h01);
    rchk(8'h03, 8'h10);
    rchk(8'h00, 8'h00);
    wr(8'h02, 8'h87);
    hold(100);
    `CHK(gap >= LAT + 2 && gap <= LAT + 3, 1'b1)
    rchk(8'h02, 8'h83);
    light_val = 12'h123;
    hold(60);
    rdn(8'h03, 2, 12'h456, d);
    `CHK(d, 16'h1203)
    rdn(8'h03, 2, 12'h456, d);
    `CHK(d, 16'h4506)
    slow = 1'b1;
    light_val = 12'hF5A;
    hold(100);
    rdn(8'h03, 2, light_val, d);
    slow = 1'b0;
    `CHK(d, 16'hF50A)
    `CHK(divider, 1'b1)
    `CHK(time_sel, 3'h3)
    rchk(8'h02, 8'h8B);
    light_val = 12'h100;
    for (int i = 0; i < 16; i++) begin
      wr(8'h02, {4'hC, i[3:0]});
      `CHK(time_sel, i[2:0])
      `CHK(divider, i[3])
    end
    rchk(8'h02, 8'hCF);
    wr(8'h02, 8'hC3);
    wr(8'h05, 8'h50);
    wr(8'h06, 8'h20);
    wr(8'h07, 8'h00);
    light_val = 12'h50F;
    wr(8'h01, 8'h01);
    hold(60);
    `CHK(irq_w, 1'b1)
    light_val = 12'h510;
    hold(60);
    `CHK(irq_w, 1'b0)
    light_val = 12'h200;
    hold(60);
    rchk(8'h00, 8'h01);
    rchk(8'h00, 8'h00);
    `CHK(irq_w, 1'b1)
    light_val = 12'h1FF;
    hold(60);
    `CHK(irq_w, 1'b0)
    wr(8'h01, 8'h00);
    `CHK(irq_w, 1'b1)
    rchk(8'h00, 8'h00);
    light_val = 12'h300;
    wr(8'h07, 8'h02);
    wr(8'h01, 8'h01);
    light_val = 12'h510;
    hold(90);
    `CHK(irq_w, 1'b1)
    hold(160);
    `CHK(irq_w, 1'b0)
    light_val = 12'h300;
    wr(8'h07, 8'h03);
    rchk(8'h00, 8'h01);
    light_val = 12'h510;
    hold(120);
    light_val = 12'h300;
    hold(60);
    light_val = 12'h510;
    hold(120);
    `CHK(irq_w, 1'b1)
    close_out();
  end
endmodule
`default_nettype wire
